// file: hdl/ltx_cfg.svh
// Named constants for the line transmit encoder channel.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef LTX_CFG_SVH
`define LTX_CFG_SVH
// Register byte offsets on the Avalon-MM slave.
`define LTX_REG_CTRL 4'h0
`define LTX_REG_STATUS 4'h4
// Control register fields and reset value.
`define LTX_CTRL_RAIL 0
`define LTX_CTRL_BO 1
`define LTX_CTRL_TXEN 2
`define LTX_CTRL_MODE 5:4
`define LTX_CTRL_MASK 8'h37
`define LTX_CTRL_RST 8'h01
// Positions of the pins in the synchroniser vector.
`define LTX_NPIN 11
`define LTX_P_CLK 0
`define LTX_P_POS 1
`define LTX_P_NEG 2
`define LTX_P_MPOS 3
`define LTX_P_MNEG 4
`define LTX_P_HOST 5
`define LTX_P_RAIL 6
`define LTX_P_BO 7
`define LTX_P_TXEN 8
`define LTX_P_MODE 10:9
// Output stage index of the substitution pipeline for each code.
`define LTX_B3ZS_LAST 2'd2
`define LTX_HDB3_LAST 2'd3
// Drive monitor limit in transmit clock periods.
`define LTX_DMON_LAST 8'd127
`define LTX_DMON_LIMIT 8'd128
`endif

// file: hdl/ltx_pkg.sv
// Types shared by the line transmit encoder channel.
// Assumes nothing beyond a SystemVerilog compiler.
package ltx_pkg;
   // Line rate selection, as held in the control field and on the pins.
   typedef enum logic [1:0] {
      LTX_DS3 = 2'b00,
      LTX_STS1 = 2'b01,
      LTX_E3 = 2'b10,
      LTX_RSVD = 2'b11
   } ltx_mode_e;
   // Symbol held in the substitution pipeline.
   typedef enum logic [1:0] {
      LTX_SYM_ZERO = 2'b00,
      LTX_SYM_ONE = 2'b01,
      LTX_SYM_B = 2'b10,
      LTX_SYM_V = 2'b11
   } ltx_sym_e;
endpackage : ltx_pkg

// file: hdl/ltx_sym_if.sv
// Symbol path between the channel top and its zero-substitution encoder.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface ltx_sym_if;
   logic tick;
   logic clear;
   logic single_rail;
   logic hdb3;
   logic pos_in;
   logic neg_in;
   logic out_pos;
   logic out_neg;
   logic mark_pol;
   logic viol_pol;
   // Encoder end.
   modport enc (input tick, clear, single_rail, hdb3, pos_in, neg_in,
                output out_pos, out_neg, mark_pol, viol_pol);
   // Channel end.
   modport chan (output tick, clear, single_rail, hdb3, pos_in, neg_in,
                 input out_pos, out_neg, mark_pol, viol_pol);
endinterface : ltx_sym_if

// file: hdl/ltx_encoder.sv
// B3ZS/HDB3 zero-substitution encoder with dual-rail bypass.
// Assumes one tick per transmit bit and a clear pulse after any change of format.
`timescale 1ns/1ps
`include "ltx_cfg.svh"
module ltx_encoder (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Symbol path.
   ltx_sym_if.enc s
);
   ltx_pkg::ltx_sym_e pipe_q [4];
   ltx_pkg::ltx_sym_e out_sym;
   logic [1:0] zcnt_q;
   logic [1:0] last_idx;
   logic par_q;
   logic mark_q;
   logic viol_q;
   logic one_in;
   logic subst;
   logic [2:0] zrun_q;
   logic vpar_q;
   logic seen_v_q;
   logic started_q;

   // Pipeline length and run detection follow the selected code.
   assign last_idx = s.hdb3 ? `LTX_HDB3_LAST : `LTX_B3ZS_LAST;
   assign one_in = s.pos_in | s.neg_in;
   assign subst = !one_in && (zcnt_q == last_idx);
   assign out_sym = pipe_q[last_idx];
   assign s.mark_pol = mark_q;
   assign s.viol_pol = viol_q;

   // Delay line; a full zero run ends in V, and starts with B when the parity is even.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) pipe_q[i] <= ltx_pkg::LTX_SYM_ZERO;
      end else if (s.clear) begin
         for (int i = 0; i < 4; i++) pipe_q[i] <= ltx_pkg::LTX_SYM_ZERO;
      end else if (s.tick && s.single_rail) begin
         for (int i = 3; i > 0; i--) pipe_q[i] <= pipe_q[i - 1];
         pipe_q[0] <= one_in ? ltx_pkg::LTX_SYM_ONE :
                      (subst ? ltx_pkg::LTX_SYM_V : ltx_pkg::LTX_SYM_ZERO);
         if (subst && !par_q) pipe_q[last_idx] <= ltx_pkg::LTX_SYM_B;
      end
   end

   // Zero run length and pulse parity since the last violation.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         zcnt_q <= `LTX_B3ZS_LAST;
         par_q <= 1'b0;
      end else if (s.clear) begin
         zcnt_q <= last_idx;
         par_q <= 1'b0;
      end else if (s.tick && s.single_rail) begin
         if (one_in) begin
            zcnt_q <= 2'h0;
            par_q <= ~par_q;
         end else if (subst) begin
            zcnt_q <= 2'h0;
            par_q <= 1'b0;
         end else begin
            zcnt_q <= zcnt_q + 2'h1;
         end
      end
   end

   // Polarity assignment; marks alternate and a violation repeats the last mark.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s.out_pos <= 1'b0;
         s.out_neg <= 1'b0;
         mark_q <= 1'b0;
         viol_q <= 1'b0;
      end else if (s.clear) begin
         s.out_pos <= 1'b0;
         s.out_neg <= 1'b0;
      end else if (s.tick && !s.single_rail) begin
         s.out_pos <= s.pos_in & ~s.neg_in;
         s.out_neg <= s.neg_in & ~s.pos_in;
      end else if (s.tick) begin
         unique case (out_sym)
            ltx_pkg::LTX_SYM_ZERO: begin
               s.out_pos <= 1'b0;
               s.out_neg <= 1'b0;
            end
            ltx_pkg::LTX_SYM_ONE, ltx_pkg::LTX_SYM_B: begin
               s.out_pos <= ~mark_q;
               s.out_neg <= mark_q;
               mark_q <= ~mark_q;
            end
            ltx_pkg::LTX_SYM_V: begin
               s.out_pos <= mark_q;
               s.out_neg <= ~mark_q;
               viol_q <= mark_q;
            end
         endcase
      end
   end

   // Output run length and pulse parity, watched by the checks below.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         zrun_q <= 3'h0;
         vpar_q <= 1'b0;
         seen_v_q <= 1'b0;
         started_q <= 1'b0;
      end else if (s.clear) begin
         zrun_q <= 3'h0;
         vpar_q <= 1'b0;
         seen_v_q <= 1'b0;
         started_q <= 1'b0;
      end else if (s.tick && s.single_rail) begin
         if (out_sym != ltx_pkg::LTX_SYM_ZERO) started_q <= 1'b1;
         if (out_sym == ltx_pkg::LTX_SYM_ZERO && started_q) zrun_q <= zrun_q + 3'h1;
         else if (out_sym != ltx_pkg::LTX_SYM_ZERO) zrun_q <= 3'h0;
         if (out_sym == ltx_pkg::LTX_SYM_V) begin
            vpar_q <= 1'b0;
            seen_v_q <= 1'b1;
         end else if (out_sym != ltx_pkg::LTX_SYM_ZERO) begin
            vpar_q <= ~vpar_q;
         end
      end
   end

   default clocking enc_cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // A coded bit step in single-rail format.
   sequence enc_step;
      s.tick && s.single_rail && !s.clear;
   endsequence

   b3zs_run_a: assert property (s.single_rail && !s.hdb3 && !s.clear |-> zrun_q < 3'd3)
      else $error("B3ZS output holds three zeros in a row");
   hdb3_run_a: assert property (s.single_rail && s.hdb3 && !s.clear |-> zrun_q < 3'd4)
      else $error("HDB3 output holds four zeros in a row");
   odd_pulse_a: assert property (
      enc_step ##0 (out_sym == ltx_pkg::LTX_SYM_V) && seen_v_q |-> vpar_q)
      else $error("Even pulse count between violations");
   viol_pol_a: assert property (
      enc_step ##0 (out_sym == ltx_pkg::LTX_SYM_V) |=> (s.out_pos == $past(mark_q)) && s.out_neg != s.out_pos)
      else $error("Violation does not repeat last mark polarity");
   bypass_rail_a: assert property (
      s.tick && !s.single_rail && !s.clear |=> s.out_pos == $past(s.pos_in & ~s.neg_in)
         && s.out_neg == $past(s.neg_in & ~s.pos_in))
      else $error("Dual-rail data not passed straight through");
   neg_as_mark_a: assert property (enc_step ##0 s.neg_in |=> zcnt_q == 2'h0)
      else $error("Negative rail pulse not taken as data mark");
endmodule : ltx_encoder

// file: hdl/ltx_drive_mon.sv
// Drive monitor: flags a transmit line that shows no transitions.
// Assumes synchronised monitor levels and one tick per transmit clock period.
`timescale 1ns/1ps
`include "ltx_cfg.svh"
module ltx_drive_mon (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Monitored line and period tick.
   input wire logic tick,
   input wire logic mon_pos,
   input wire logic mon_neg,
   // Fault flag.
   output logic fault
);
   logic mp_q;
   logic mn_q;
   logic [7:0] idle_q;
   logic trans;

   assign trans = (mon_pos != mp_q) || (mon_neg != mn_q);

   // Previous levels for transition detection.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mp_q <= 1'b0;
         mn_q <= 1'b0;
      end else begin
         mp_q <= mon_pos;
         mn_q <= mon_neg;
      end
   end

   // Periods since the last transition, saturating at the limit.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) idle_q <= 8'h00;
      else if (trans) idle_q <= 8'h00;
      else if (tick && idle_q != `LTX_DMON_LIMIT) idle_q <= idle_q + 8'h01;
   end

   // Fault rises at the limit and falls on the next transition.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) fault <= 1'b0;
      else if (trans) fault <= 1'b0;
      else if (tick && idle_q == `LTX_DMON_LAST) fault <= 1'b1;
   end

   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   fault_clear_a: assert property (trans |=> !fault)
      else $error("Drive fault not cleared by a transition");
   fault_set_a: assert property ($rose(fault) |-> $past(idle_q) == `LTX_DMON_LAST && $past(tick))
      else $error("Drive fault raised at the wrong period count");
   fault_due_a: assert property (tick && !trans && idle_q == `LTX_DMON_LAST |=> fault)
      else $error("Drive fault missing after idle limit");
endmodule : ltx_drive_mon

// file: hdl/ltx_channel.sv
// Transmit path of one line interface channel: pin synchronisers, configuration,
// Avalon-MM registers, clock duty regeneration, encoder and drive monitor.
// Assumes all pins are asynchronous to core_clk and the transmit clock is much slower.
//
// Behaviour
// - Line rate per channel from pins or register, chosen by host mode.
// - Single-rail chosen by rail pin high or control bit 0 set.
// - Dual-rail carries positive pulses and negative pulses on separate inputs.
// - Accept 30 to 70 percent duty clock, regenerate 50 percent copy.
// - Single-rail uses B3ZS for DS3 or STS-1 and HDB3 for E3.
// - B3ZS replaces three zeros with B0V or 00V.
// - Pattern choice keeps an odd pulse count between violations.
// - HDB3 replaces four zeros with 000V or B00V, odd pulses between.
// - Dual-rail format bypasses the zero-substitution encoder.
// - Violations in single-rail input become valid data pulses.
// - Build-out enabled by control pin low or control bit 1 clear, disabled otherwise.
// - E3 keeps build-out disabled regardless of control.
// - Drive fault stays low while the monitored line toggles.
// - No transition for 128 periods raises fault; transitions clear it.
// - Transmitter on by enable pin, in host mode also needing bit set.
// - Transmitter off places both line outputs in high impedance.
// - Host bit set hands transmitter control to the enable pin.
`timescale 1ns/1ps
`include "ltx_cfg.svh"
module ltx_channel (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Configuration and control pins.
   input wire logic host_mode,
   input wire logic rail_format_select,
   input wire logic build_out_control,
   input wire logic transmitter_enable,
   input wire logic [1:0] line_mode_select,
   // Terminal transmit data.
   input wire logic tx_line_clock,
   input wire logic tx_pos_data_in,
   input wire logic tx_neg_data_in,
   // Drive monitor.
   input wire logic monitor_pos_input,
   input wire logic monitor_neg_input,
   output logic drive_fault_flag,
   // Pulse shaper and line driver.
   output logic line_out_pos,
   output logic line_out_neg,
   output logic line_out_pos_oe_n,
   output logic line_out_neg_oe_n,
   output logic build_out_enable,
   output logic shaper_clk
);
   logic [`LTX_NPIN-1:0] pin_raw;
   logic [`LTX_NPIN-1:0] sy1_q;
   logic [`LTX_NPIN-1:0] sy2_q;
   logic [`LTX_NPIN-1:0] sy3_q;
   logic [`LTX_NPIN-1:0] pin_q;
   logic clk_prev_q;
   logic tick;
   logic [7:0] ctrl_q;
   logic ack_q;
   logic single_q;
   ltx_pkg::ltx_mode_e mode_q;
   logic bo_dis_q;
   logic tx_on_q;
   logic [2:0] cfg_prev_q;
   logic hdb3;
   logic [7:0] per_cnt_q;
   logic [7:0] per_q;
   logic [7:0] hi_q;
   logic fault;
   ltx_sym_if sif ();

   // Half of a measured period, in core cycles.
   function automatic logic [7:0] ltx_half(input logic [7:0] per);
      ltx_half = {1'b0, per[7:1]};
   endfunction : ltx_half

   // True when a bus address selects the given register.
   function automatic logic ltx_hit(input logic [3:0] addr, input logic [3:0] off);
      ltx_hit = (addr == off);
   endfunction : ltx_hit

   // Gather every asynchronous pin into one vector.
   always_comb begin
      pin_raw = '0;
      pin_raw[`LTX_P_CLK] = tx_line_clock;
      pin_raw[`LTX_P_POS] = tx_pos_data_in;
      pin_raw[`LTX_P_NEG] = tx_neg_data_in;
      pin_raw[`LTX_P_MPOS] = monitor_pos_input;
      pin_raw[`LTX_P_MNEG] = monitor_neg_input;
      pin_raw[`LTX_P_HOST] = host_mode;
      pin_raw[`LTX_P_RAIL] = rail_format_select;
      pin_raw[`LTX_P_BO] = build_out_control;
      pin_raw[`LTX_P_TXEN] = transmitter_enable;
      pin_raw[`LTX_P_MODE] = line_mode_select;
   end

   // Three-stage synchroniser chain.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sy1_q <= '0;
         sy2_q <= '0;
         sy3_q <= '0;
      end else begin
         sy1_q <= pin_raw;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
      end
   end

   // A pin level is accepted only where the second and third stages agree.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) pin_q <= '0;
      else pin_q <= (sy2_q & sy3_q) | (pin_q & (sy2_q ^ sy3_q));
   end

   // Rising edge of the transmit clock; data is sampled on it.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) clk_prev_q <= 1'b0;
      else clk_prev_q <= pin_q[`LTX_P_CLK];
   end
   assign tick = pin_q[`LTX_P_CLK] & ~clk_prev_q;

   // Effective configuration from pins or from the control register.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         single_q <= 1'b0;
         mode_q <= ltx_pkg::LTX_DS3;
         bo_dis_q <= 1'b0;
         tx_on_q <= 1'b0;
      end else if (pin_q[`LTX_P_HOST]) begin
         single_q <= ctrl_q[`LTX_CTRL_RAIL];
         mode_q <= ltx_pkg::ltx_mode_e'(ctrl_q[`LTX_CTRL_MODE]);
         bo_dis_q <= ctrl_q[`LTX_CTRL_BO];
         tx_on_q <= ctrl_q[`LTX_CTRL_TXEN] & pin_q[`LTX_P_TXEN];
      end else begin
         single_q <= pin_q[`LTX_P_RAIL];
         mode_q <= ltx_pkg::ltx_mode_e'(pin_q[`LTX_P_MODE]);
         bo_dis_q <= pin_q[`LTX_P_BO];
         tx_on_q <= pin_q[`LTX_P_TXEN];
      end
   end

   assign hdb3 = (mode_q == ltx_pkg::LTX_E3);

   // Previous format, so that a change flushes the encoder.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) cfg_prev_q <= 3'h0;
      else cfg_prev_q <= {single_q, mode_q};
   end

   // Build-out drive and tri-state enables, all from flip-flops.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         build_out_enable <= 1'b0;
         line_out_pos_oe_n <= 1'b1;
         line_out_neg_oe_n <= 1'b1;
      end else begin
         build_out_enable <= !bo_dis_q && !hdb3;
         line_out_pos_oe_n <= !tx_on_q;
         line_out_neg_oe_n <= !tx_on_q;
      end
   end

   // Avalon-MM handshake: every access waits exactly one cycle.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) ack_q <= 1'b0;
      else ack_q <= (avs_read | avs_write) & ~ack_q;
   end

   // Control register; writes land on the edge where waitrequest is low.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) ctrl_q <= `LTX_CTRL_RST;
      else if (avs_write && ack_q && avs_byteenable[0] && ltx_hit(avs_address, `LTX_REG_CTRL))
         ctrl_q <= avs_writedata[7:0] & `LTX_CTRL_MASK;
   end

   // Read data, loaded one edge before it is presented.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         if (ltx_hit(avs_address, `LTX_REG_CTRL))
            avs_readdata <= {24'h00_0000, ctrl_q};
         else if (ltx_hit(avs_address, `LTX_REG_STATUS))
            avs_readdata <= {22'h00_0000, mode_q, 2'h0, single_q, sif.viol_pol,
                             sif.mark_pol, build_out_enable, tx_on_q, fault};
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

   // Measure the transmit clock period in core cycles.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         per_cnt_q <= 8'h00;
         per_q <= 8'h00;
      end else if (tick) begin
         per_q <= per_cnt_q;
         per_cnt_q <= 8'h01;
      end else if (per_cnt_q != 8'hFF) begin
         per_cnt_q <= per_cnt_q + 8'h01;
      end
   end

   // Regenerated shaper clock: high for half the measured period.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shaper_clk <= 1'b0;
         hi_q <= 8'h00;
      end else if (tick) begin
         shaper_clk <= 1'b1;
         hi_q <= 8'h01;
      end else if (shaper_clk && hi_q >= ltx_half(per_q)) begin
         shaper_clk <= 1'b0;
      end else if (shaper_clk) begin
         hi_q <= hi_q + 8'h01;
      end
   end

   // Encoder feed.
   assign sif.tick = tick;
   assign sif.clear = (cfg_prev_q != {single_q, mode_q});
   assign sif.single_rail = single_q;
   assign sif.hdb3 = hdb3;
   assign sif.pos_in = pin_q[`LTX_P_POS];
   assign sif.neg_in = pin_q[`LTX_P_NEG];
   assign line_out_pos = sif.out_pos;
   assign line_out_neg = sif.out_neg;
   assign drive_fault_flag = fault;

   ltx_encoder u_enc (
      .core_clk(core_clk),
      .rstn(rstn),
      .s(sif.enc)
   );

   ltx_drive_mon u_mon (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick(tick),
      .mon_pos(pin_q[`LTX_P_MPOS]),
      .mon_neg(pin_q[`LTX_P_MNEG]),
      .fault(fault)
   );

   default clocking ch_cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // A bus request that is held through its single wait cycle.
   sequence bus_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   bus_answer_a: assert property (bus_wait |=> !avs_waitrequest)
      else $error("Bus request not answered after one wait cycle");
   e3_buildout_a: assert property (hdb3 |=> !build_out_enable)
      else $error("Build-out enabled in E3 mode");
   buildout_ctrl_a: assert property (!hdb3 |=> build_out_enable == !$past(bo_dis_q))
      else $error("Build-out does not follow its control");
   tri_state_a: assert property (!tx_on_q |=> line_out_pos_oe_n && line_out_neg_oe_n)
      else $error("Line driven while transmitter off");
   txen_pin_a: assert property (!pin_q[`LTX_P_TXEN] |=> !tx_on_q ##1 line_out_pos_oe_n)
      else $error("Transmitter on with enable pin low");
   host_handover_a: assert property (
      pin_q[`LTX_P_HOST] && ctrl_q[`LTX_CTRL_TXEN] |=> tx_on_q == $past(pin_q[`LTX_P_TXEN]))
      else $error("Enable pin not in control after host bit set");
   rail_sel_a: assert property (
      pin_q[`LTX_P_HOST] |=> single_q == $past(ctrl_q[`LTX_CTRL_RAIL]))
      else $error("Rail format does not follow control bit");
   duty_half_a: assert property ($fell(shaper_clk) && !$past(tick) |->
      $past(hi_q) == ltx_half($past(per_q)) || $past(hi_q) > ltx_half($past(per_q)))
      else $error("Shaper clock high time is not half the period");

   // Hardware mode takes the rail format and line rate from the pins.
   hw_rail_a: assert property (
      !pin_q[`LTX_P_HOST] |=> single_q == $past(pin_q[`LTX_P_RAIL]))
      else $error("Rail format does not follow its pin");
   mode_pin_a: assert property (
      !pin_q[`LTX_P_HOST] |=> mode_q == $past(pin_q[`LTX_P_MODE]))
      else $error("Line rate does not follow its pins");

   // A transmitter that is on drives both line outputs.
   oe_on_a: assert property (tx_on_q |=> !line_out_pos_oe_n && !line_out_neg_oe_n)
      else $error("Line not driven while transmitter on");

   // Every transmit clock rise opens the regenerated high phase.
   shaper_rise_a: assert property (tick |=> shaper_clk)
      else $error("Shaper clock not raised by the transmit clock");

   // An accepted control write keeps only the defined bits.
   ctrl_write_a: assert property (
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == `LTX_REG_CTRL
      |=> ctrl_q == ($past(avs_writedata[7:0]) & `LTX_CTRL_MASK))
      else $error("Control write did not land");
endmodule : ltx_channel

// file: test/ltx_term_model.sv
// Terminal framer model: transmit clock and data for one channel.
// Assumes the bench changes patterns only while run is low.
`timescale 1ns/1ps
module ltx_term_model (
   // Control.
   input wire logic run,
   input wire logic [31:0] pat_pos,
   input wire logic [31:0] pat_neg,
   // Line side.
   output logic clk_out,
   output logic pos_out,
   output logic neg_out
);
   int k = 0;
   // Clock of 160 ns, high for only 48 ns of it, runs while enabled; data moves on its fall.
   initial begin
      clk_out = 0;
      pos_out = 0;
      neg_out = 0;
      forever begin
         #(clk_out ? 48 : 112) clk_out = run & ~clk_out;
         if (!clk_out) begin
            pos_out = pat_pos[k];
            neg_out = pat_neg[k];
            k = (k + 1) % 32;
         end
      end
   end
endmodule : ltx_term_model

// file: test/test_ltx_channel.sv
// Bench for the transmit encoder channel: registers, line coding, pins.
// Assumes the terminal model ltx_term_model drives the transmit side.
`timescale 1ns/1ps
module test_ltx_channel;
   logic core_clk = 0, rstn = 0, rd = 0, wr = 0, host = 0, rail = 1, bo = 0, txen = 1;
   logic run = 0, cut = 0, tc, tp, tn, lp, ln, lpo, lno, boe, flag, wq, sc;
   logic [1:0] mode = 0;
   logic [3:0] adr = 0;
   logic [31:0] wd = 0, rdat, pp = 0, pn = 0, d;
   int bad_count = 0, checked = 0, p, n, s;
   ltx_term_model TERM (.run(run), .pat_pos(pp), .pat_neg(pn), .clk_out(tc),
      .pos_out(tp), .neg_out(tn));
   ltx_channel DUT (.core_clk(core_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
      .avs_waitrequest(wq), .host_mode(host), .rail_format_select(rail),
      .build_out_control(bo), .transmitter_enable(txen), .line_mode_select(mode),
      .tx_line_clock(tc), .tx_pos_data_in(tp), .tx_neg_data_in(tn),
      .monitor_pos_input(lp & ~cut), .monitor_neg_input(ln & ~cut),
      .drive_fault_flag(flag), .line_out_pos(lp), .line_out_neg(ln),
      .line_out_pos_oe_n(lpo), .line_out_neg_oe_n(lno), .build_out_enable(boe),
      .shaper_clk(sc));
   // Ends the run with the verdict.
   task summarize;
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   // Compares a seen value with the expected one.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits a number of core cycles.
   task cy(input int c);
      repeat (c) @(posedge core_clk);
   endtask : cy
   // One Avalon transfer, held until waitrequest is seen low.
   task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
      int i;
      @(posedge core_clk);
      adr <= a;
      wd <= v;
      wr <= w;
      rd <= !w;
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         if (wq === 1'b0) break;
      end
      d = rdat;
      rd <= 0;
      wr <= 0;
      if (i == 40) begin
         bad_count++;
         summarize();
      end
   endtask : bus
   // Runs the line, counts bit periods with each strobe high and shaper high cycles.
   task lr(input logic r, input logic [1:0] m, input logic [31:0] a, b, input int ep, en);
      rail <= r;
      mode <= m;
      pp <= a;
      pn <= b;
      cy(20);
      run <= 1;
      cy(128);
      p = 0;
      n = 0;
      s = 0;
      repeat (768) begin
         @(posedge core_clk);
         p += lp;
         n += ln;
         s += sc;
      end
      run <= 0;
      chk(p / 8, ep);
      chk(n / 8, en);
      chk(s, 768 / 2);
   endtask : lr
   // Register access, unmapped place and host configuration.
   task t_regs;
      bus(0, 0, 0);
      chk(d, 32'h01);
      bus(1, 0, 32'hFF);
      bus(0, 0, 0);
      chk(d, 32'h37);
      bus(0, 4'h8, 0);
      chk(d, 0);
      host <= 1;
      bus(1, 0, 32'h24);
      cy(10);
      bus(0, 4'h4, 0);
      chk({d[9:8], d[5], d[2:0]}, 6'h22);
      bus(1, 0, 32'h01);
      host <= 0;
   endtask : t_regs
   // Build-out output for every mode and control level.
   task t_bo;
      for (int i = 0; i < 8; i++) begin
         mode <= i[2:1];
         bo <= i[0];
         cy(10);
         chk(boe, i[2:1] != 2'd2 && !i[0]);
      end
      mode <= 0;
      bo <= 0;
   endtask : t_bo
   // Transmitter on and off from pin and control bit.
   task t_txen;
      txen <= 0;
      cy(10);
      chk({lpo, lno}, 2'b11);
      txen <= 1;
      cy(10);
      chk({lpo, lno}, 2'b00);
      host <= 1;
      bus(1, 0, 32'h01);
      cy(10);
      chk({lpo, lno}, 2'b11);
      bus(1, 0, 32'h05);
      cy(10);
      chk({lpo, lno}, 2'b00);
      txen <= 0;
      cy(10);
      chk({lpo, lno}, 2'b11);
      txen <= 1;
      host <= 0;
   endtask : t_txen
   // Drive monitor with the line watched, then cut, then restored.
   task t_mon;
      int i;
      rail <= 1;
      pp <= 0;
      pn <= 0;
      cy(20);
      run <= 1;
      cy(400);
      chk(flag, 0);
      cut <= 1;
      cy(760);
      chk(flag, 0);
      for (i = 0; i < 520 && flag !== 1'b1; i++) @(posedge core_clk);
      chk(flag, 1);
      cut <= 0;
      cy(20);
      chk(flag, 0);
      run <= 0;
   endtask : t_mon
   // Core clock of 20 ns.
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   // Main sequence.
   initial begin
      cy(6);
      rstn <= 1;
      t_regs();
      t_bo();
      t_txen();
      lr(0, 0, 32'hA5A50F0F, 32'h0000F0F0, 48, 24);
      lr(1, 0, 0, 0, 32, 32);
      lr(1, 2, 0, 0, 24, 24);
      lr(1, 0, 32'h88888888, 0, 24, 24);
      lr(1, 2, 32'h80808080, 0, 12, 12);
      lr(1, 0, 0, 32'hFFFFFFFF, 48, 48);
      t_mon();
      summarize();
   end
endmodule : test_ltx_channel
